/* rtl/swc_pkg.sv */
// Constants, bit positions and types shared by the sleep and wake controller.
// Assumes a 100 MHz system clock and control words supplied by the core.
`default_nettype none

package swc_pkg;

  // Clock speed control word
  localparam int CSC_MULT_LSB = 0;
  localparam int CSC_MULT_W = 8;
  localparam int CSC_TRIM_EN_BIT = 8;
  localparam int CSC_XTAL_EN_BIT = 9;
  localparam int CSC_IDLE_BIT = 10;

  // Interrupt and general control word
  localparam int IGC_T1_SRC_BIT = 8;
  localparam int IGC_T2_SRC_BIT = 9;
  localparam int IGC_T1_EN_BIT = 10;
  localparam int IGC_T2_EN_BIT = 11;
  localparam int IGC_ASYNC_BIT = 14;

  // Interrupt mask positions in the low byte of the control word
  localparam int MSK_W = 5;
  localparam int MSK_CONV = 0;
  localparam int MSK_T1 = 1;
  localparam int MSK_T2 = 2;
  localparam int MSK_PORTD = 3;
  localparam int MSK_PORTF = 4;

  // Port D wake pins and their active edge, 1 = rising
  localparam int PORTD_LO = 2;
  localparam int PORTD_N = 4;
  localparam logic [3:0] PORTD_RISE = 4'h0;

  // Oscillator restart times and derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int TRIM_START_US = 20;
  localparam int XTAL_START_US = 200;
  localparam int TRIM_START_CYC = TRIM_START_US * CLK_MHZ;
  localparam int XTAL_START_CYC = XTAL_START_US * CLK_MHZ;
  localparam int SETTLE_W = 16;

  // Wake source codes
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_RESET = 3'h1;
  localparam logic [2:0] SRC_T1 = 3'h2;
  localparam logic [2:0] SRC_T2 = 3'h3;
  localparam logic [2:0] SRC_PORTD = 3'h4;
  localparam logic [2:0] SRC_PORTF = 3'h5;
  localparam logic [2:0] SRC_CONV = 3'h6;

  typedef enum logic [1:0] {ST_AWAKE, ST_ASLEEP} swc_state_t;
  typedef enum logic [1:0] {LVL_LIGHT, LVL_MID, LVL_DEEP, LVL_OTHER} swc_level_t;

endpackage

`default_nettype wire

/* rtl/swc_wake_edges.sv */
// Edge detection for the external wake pins and the reset pin.
// Assumes all pin inputs are already synchronous to clk.
`default_nettype none

module swc_wake_edges import swc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pins
  input wire logic reset_pin,
  input wire logic [7:0] port_f_pins,
  input wire logic [7:0] port_d_pins,
  input wire logic [7:0] port_d_dir,
  // Events
  output logic reset_rise,
  output logic port_f_fall,
  output logic [PORTD_N-1:0] port_d_edge
);

  logic reset_prev;
  logic f_all_prev;
  logic [PORTD_N-1:0] d_prev;

  // Reset pin low-to-high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_prev <= 1'b1;
      reset_rise <= 1'b0;
    end else begin
      reset_prev <= reset_pin;
      reset_rise <= reset_pin & ~reset_prev;
    end
  end

  // Port F fires only when all pins were high and one drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      f_all_prev <= 1'b1;
      port_f_fall <= 1'b0;
    end else begin
      f_all_prev <= &port_f_pins;
      port_f_fall <= f_all_prev & ~(&port_f_pins);
    end
  end

  // Port D pins wake only while configured as inputs
  for (genvar i = 0; i < PORTD_N; i++) begin : g_portd
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        d_prev[i] <= 1'b0;
        port_d_edge[i] <= 1'b0;
      end else begin
        d_prev[i] <= port_d_pins[PORTD_LO+i];
        port_d_edge[i] <= ~port_d_dir[PORTD_LO+i] &
          (PORTD_RISE[i] ? (port_d_pins[PORTD_LO+i] & ~d_prev[i])
                         : (~port_d_pins[PORTD_LO+i] & d_prev[i]));
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/swc_sleep_ctrl.sv */
// Sleep and wake-up controller: clock gating during sleep and wake decisions.
// Assumes control words, timer underflows and pins are synchronous to clk.
`default_nettype none

module swc_sleep_ctrl import swc_pkg::*; #(
  parameter int TRIM_SETTLE = TRIM_START_CYC,
  parameter int XTAL_SETTLE = XTAL_START_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Core side
  input wire logic sleep_instr,
  input wire logic global_irq_enable_instr,
  input wire logic [15:0] clock_speed_control_reg,
  input wire logic [15:0] interrupt_general_control_reg,
  input wire logic converter_enable,
  input wire logic pulse_density_output,
  // Wake sources
  input wire logic reset_pin,
  input wire logic first_countdown_timer_uf,
  input wire logic second_countdown_timer_uf,
  input wire logic converter_timer_uf,
  input wire logic [7:0] port_f_pins,
  input wire logic [7:0] port_d_pins,
  input wire logic [7:0] port_d_dir,
  // Clock controls
  output logic cpu_clk_run,
  output logic pll_run,
  output logic periph_master_clock_run,
  output logic ref_osc_run,
  output logic first_timer_clk_run,
  output logic second_timer_clk_run,
  output logic [7:0] pll_multiplier,
  output logic async_wake_active,
  output logic core_full_speed,
  // Sleep status
  output logic asleep,
  output logic [1:0] sleep_level,
  // Wake result
  output logic wake_pulse,
  output logic goto_irq_vector,
  output logic resume_after_sleep,
  output logic goto_reset_vector,
  output logic [2:0] wake_source
);

  function automatic logic osc_enabled(input logic [15:0] csc);
    osc_enabled = csc[CSC_TRIM_EN_BIT] | csc[CSC_XTAL_EN_BIT];
  endfunction

  function automatic swc_level_t level_of(input logic idle, input logic osc, input logic async_m);
    if (!idle && osc && !async_m) begin
      level_of = LVL_LIGHT;
    end else if (idle && osc && async_m) begin
      level_of = LVL_MID;
    end else if (idle && !osc && async_m) begin
      level_of = LVL_DEEP;
    end else begin
      level_of = LVL_OTHER;
    end
  endfunction

  swc_state_t state;
  logic cap_idle;
  logic cap_osc;
  logic cap_xtal;
  logic cap_async;
  logic cap_gie;
  logic cap_conv;
  logic [MSK_W-1:0] cap_mask;
  logic cap_t1_en;
  logic cap_t1_ref;
  logic cap_t2_en;
  logic cap_t2_ref;
  logic osc_prev;
  logic [SETTLE_W-1:0] settle_cnt;

  logic reset_rise;
  logic port_f_fall;
  logic [PORTD_N-1:0] port_d_edge;

  logic osc_live;
  logic enter_sleep;
  logic mclk_sleep;
  logic t1_sleep;
  logic t2_sleep;
  logic visible;
  logic wk_t1;
  logic wk_t2;
  logic wk_d;
  logic wk_f;
  logic wk_conv;
  logic wake_any;
  logic [2:0] next_source;
  logic settle_start;

  swc_wake_edges u_edges (
    .clk(clk),
    .arst_n(arst_n),
    .reset_pin(reset_pin),
    .port_f_pins(port_f_pins),
    .port_d_pins(port_d_pins),
    .port_d_dir(port_d_dir),
    .reset_rise(reset_rise),
    .port_f_fall(port_f_fall),
    .port_d_edge(port_d_edge)
  );

  assign osc_live = osc_enabled(clock_speed_control_reg);
  assign enter_sleep = (state == ST_AWAKE) && sleep_instr;

  // Clock status implied by the captured controls
  assign mclk_sleep = !cap_idle && cap_osc;
  assign t1_sleep = cap_t1_en && (cap_t1_ref ? cap_osc : mclk_sleep);
  assign t2_sleep = cap_t2_en && (cap_t2_ref ? cap_osc : mclk_sleep);
  // Synchronous path needs the master clock, async path does not
  assign visible = mclk_sleep || cap_async;

  // Wake qualification
  assign wk_t1 = first_countdown_timer_uf && cap_mask[MSK_T1] && t1_sleep && visible;
  assign wk_t2 = second_countdown_timer_uf && cap_mask[MSK_T2] && t2_sleep && visible;
  assign wk_d = (|port_d_edge) && cap_mask[MSK_PORTD] && visible;
  assign wk_f = port_f_fall && cap_mask[MSK_PORTF] && visible;
  assign wk_conv = converter_timer_uf && cap_mask[MSK_CONV] && cap_conv && visible;
  assign wake_any = (state == ST_ASLEEP) && (reset_rise || wk_t1 || wk_t2 || wk_d || wk_f || wk_conv);

  always_comb begin
    next_source = SRC_NONE;
    if (reset_rise) begin
      next_source = SRC_RESET;
    end else if (wk_t1) begin
      next_source = SRC_T1;
    end else if (wk_t2) begin
      next_source = SRC_T2;
    end else if (wk_d) begin
      next_source = SRC_PORTD;
    end else if (wk_f) begin
      next_source = SRC_PORTF;
    end else if (wk_conv) begin
      next_source = SRC_CONV;
    end
  end

  // Sleep state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_AWAKE;
    end else begin
      case (state)
        ST_AWAKE: begin
          if (sleep_instr) begin
            state <= ST_ASLEEP;
          end
        end
        ST_ASLEEP: begin
          if (wake_any) begin
            state <= ST_AWAKE;
          end
        end
        default: begin
          state <= ST_AWAKE;
        end
      endcase
    end
  end

  // Controls sampled at the sleep instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_idle <= 1'b0;
      cap_osc <= 1'b0;
      cap_xtal <= 1'b0;
      cap_async <= 1'b0;
      cap_gie <= 1'b0;
      cap_conv <= 1'b0;
      cap_mask <= '0;
      cap_t1_en <= 1'b0;
      cap_t1_ref <= 1'b0;
      cap_t2_en <= 1'b0;
      cap_t2_ref <= 1'b0;
    end else if (enter_sleep) begin
      cap_idle <= clock_speed_control_reg[CSC_IDLE_BIT];
      cap_osc <= osc_live;
      cap_xtal <= clock_speed_control_reg[CSC_XTAL_EN_BIT];
      cap_async <= interrupt_general_control_reg[IGC_ASYNC_BIT];
      cap_gie <= global_irq_enable_instr;
      cap_conv <= converter_enable | pulse_density_output;
      cap_mask <= interrupt_general_control_reg[MSK_W-1:0];
      cap_t1_en <= interrupt_general_control_reg[IGC_T1_EN_BIT];
      cap_t1_ref <= interrupt_general_control_reg[IGC_T1_SRC_BIT];
      cap_t2_en <= interrupt_general_control_reg[IGC_T2_EN_BIT];
      cap_t2_ref <= interrupt_general_control_reg[IGC_T2_SRC_BIT];
    end
  end

  // Clock enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      asleep <= 1'b0;
      cpu_clk_run <= 1'b1;
      pll_run <= 1'b1;
      periph_master_clock_run <= 1'b1;
      ref_osc_run <= 1'b0;
      first_timer_clk_run <= 1'b0;
      second_timer_clk_run <= 1'b0;
      async_wake_active <= 1'b0;
      sleep_level <= 2'h0;
    end else if ((state == ST_ASLEEP) && !wake_any) begin
      asleep <= 1'b1;
      cpu_clk_run <= 1'b0;
      pll_run <= mclk_sleep;
      periph_master_clock_run <= mclk_sleep;
      ref_osc_run <= cap_osc;
      first_timer_clk_run <= t1_sleep;
      second_timer_clk_run <= t2_sleep;
      async_wake_active <= cap_async;
      sleep_level <= level_of(cap_idle, cap_osc, cap_async);
    end else begin
      asleep <= 1'b0;
      cpu_clk_run <= 1'b1;
      pll_run <= 1'b1;
      periph_master_clock_run <= 1'b1;
      ref_osc_run <= osc_live;
      first_timer_clk_run <= interrupt_general_control_reg[IGC_T1_EN_BIT] &&
        (!interrupt_general_control_reg[IGC_T1_SRC_BIT] || osc_live);
      second_timer_clk_run <= interrupt_general_control_reg[IGC_T2_EN_BIT] &&
        (!interrupt_general_control_reg[IGC_T2_SRC_BIT] || osc_live);
      async_wake_active <= 1'b0;
      sleep_level <= level_of(clock_speed_control_reg[CSC_IDLE_BIT], osc_live,
        interrupt_general_control_reg[IGC_ASYNC_BIT]);
    end
  end

  // Multiplier follows the clock speed word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_multiplier <= 8'h00;
    end else begin
      pll_multiplier <= clock_speed_control_reg[CSC_MULT_LSB +: CSC_MULT_W];
    end
  end

  // Wake outcome
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_pulse <= 1'b0;
      goto_irq_vector <= 1'b0;
      resume_after_sleep <= 1'b0;
      goto_reset_vector <= 1'b0;
      wake_source <= SRC_NONE;
    end else begin
      wake_pulse <= wake_any;
      goto_reset_vector <= wake_any && reset_rise;
      goto_irq_vector <= wake_any && !reset_rise && cap_gie;
      resume_after_sleep <= wake_any && !reset_rise && !cap_gie;
      if (wake_any) begin
        wake_source <= next_source;
      end
    end
  end

  // Oscillator restart delay on enable or on wake from idle sleep with the oscillator kept on
  assign settle_start = ((state == ST_AWAKE) && osc_live && !osc_prev) ||
    (wake_any && cap_idle && cap_osc);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_prev <= 1'b0;
      settle_cnt <= '0;
      core_full_speed <= 1'b1;
    end else begin
      osc_prev <= osc_live;
      if (settle_start) begin
        settle_cnt <= (wake_any ? cap_xtal : clock_speed_control_reg[CSC_XTAL_EN_BIT]) ?
          SETTLE_W'(XTAL_SETTLE) : SETTLE_W'(TRIM_SETTLE);
        core_full_speed <= 1'b0;
      end else if (settle_cnt != '0) begin
        settle_cnt <= settle_cnt - 1'b1;
        core_full_speed <= (settle_cnt == SETTLE_W'(1));
      end else begin
        core_full_speed <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence enter_s;
    (state == ST_AWAKE) && sleep_instr;
  endsequence

  sequence wake_s;
    (state == ST_ASLEEP) && wake_any;
  endsequence

  cpu_stop_a: assert property ((state == ST_ASLEEP) && !wake_any |=> asleep && !cpu_clk_run)
    else $error("cpu clock runs in sleep");

  light_mclk_a: assert property (enter_s ##1 (state == ST_ASLEEP && !cap_idle && cap_osc && !wake_any)
    |=> periph_master_clock_run && pll_run)
    else $error("master clock stopped in light sleep");

  idle_stop_a: assert property (asleep && cap_idle |-> !pll_run && !periph_master_clock_run)
    else $error("pll or master clock running with idle control set");

  osc_hold_a: assert property (enter_s |=> ##1 (!asleep || ref_osc_run == $past(osc_live, 2)))
    else $error("reference oscillator changed state at sleep");

  reset_wake_a: assert property ((state == ST_ASLEEP) && reset_rise |=>
    wake_pulse && goto_reset_vector && wake_source == SRC_RESET && !goto_irq_vector)
    else $error("reset rise did not end sleep");

  no_async_a: assert property ((state == ST_ASLEEP) && cap_idle && !cap_async && !reset_rise
    |=> !wake_pulse)
    else $error("woke without reset while idle set and async clear");

  deep_timer_a: assert property (asleep && !cap_osc |-> !first_timer_clk_run && !second_timer_clk_run)
    else $error("timer running in deep sleep");

  mask_gate_a: assert property (wake_s ##1 (wake_source == SRC_T1) |-> ##0 cap_mask[MSK_T1])
    else $error("timer one woke with mask clear");

  vector_sel_a: assert property (wake_s ##0 !reset_rise |=> goto_irq_vector == cap_gie &&
    resume_after_sleep == !cap_gie)
    else $error("wrong wake destination");

  conv_block_a: assert property ((state == ST_ASLEEP) && !cap_conv && converter_timer_uf &&
    !reset_rise && !wk_t1 && !wk_t2 && !wk_d && !wk_f |=> !wake_pulse)
    else $error("converter timer woke with converter off");

  settle_a: assert property (settle_start |=> !core_full_speed [*8])
    else $error("core at full speed before oscillator settled");

  mult_track_a: assert property (!$stable(clock_speed_control_reg[7:0]) |=>
    pll_multiplier == $past(clock_speed_control_reg[7:0]))
    else $error("multiplier did not follow control word");

endmodule

`default_nettype wire

/* test/swc_far_model.sv */
// Far-side model: two countdown timers feeding underflow pulses.
// Assumes the controller's timer clock-run outputs gate these timers.
`default_nettype none

module swc_far_model #(
  parameter int PERIOD = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Timer clocks, index 0 first timer
  input wire logic [1:0] run,
  // Underflow pulses
  output logic [1:0] uf
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [2];

  // Counts only while clocked, reloads when stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '{PERIOD, PERIOD};
      uf <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        uf[i] <= run[i] && cnt[i] == 0;
        cnt[i] <= (!run[i] || cnt[i] == 0) ? PERIOD : cnt[i] - 1;
      end
    end
  end
endmodule

`default_nettype wire

/* test/tb.sv */
// Testbench: sleep levels, clock gating, wake sources and settle time.
// Assumes the far-side timer model and shortened settle counts.
`default_nettype none

module tb import swc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TRIM = 10;
  localparam int XTAL = 20;
  typedef struct packed {logic [2:0] src; logic irq; logic res; logic rv;} swc_exp_t;
  logic clk, arst_n, sleep_instr, gie, conv_en, pdo, rst_pin, cuf;
  logic cpu_run, pll_run, mclk_run, ref_run, t1_run, t2_run, async_act, full_speed, asleep;
  logic wake_pulse, to_irq, to_resume, to_reset;
  logic [1:0] tuf;
  logic [1:0] level;
  logic [2:0] src;
  logic [7:0] mult, pf, pd, pdir;
  logic [15:0] csc, igc;
  logic [31:0] rnd;
  swc_exp_t exp_q [$];
  int num_errors, check_count, cycles;

  swc_sleep_ctrl #(.TRIM_SETTLE(TRIM), .XTAL_SETTLE(XTAL)) swc_sleep_ctrl_i (
    .clk(clk), .arst_n(arst_n), .sleep_instr(sleep_instr), .global_irq_enable_instr(gie),
    .clock_speed_control_reg(csc), .interrupt_general_control_reg(igc),
    .converter_enable(conv_en), .pulse_density_output(pdo), .reset_pin(rst_pin),
    .first_countdown_timer_uf(tuf[0]), .second_countdown_timer_uf(tuf[1]),
    .converter_timer_uf(cuf), .port_f_pins(pf), .port_d_pins(pd), .port_d_dir(pdir),
    .cpu_clk_run(cpu_run), .pll_run(pll_run), .periph_master_clock_run(mclk_run),
    .ref_osc_run(ref_run), .first_timer_clk_run(t1_run), .second_timer_clk_run(t2_run),
    .pll_multiplier(mult), .async_wake_active(async_act), .core_full_speed(full_speed),
    .asleep(asleep), .sleep_level(level), .wake_pulse(wake_pulse), .goto_irq_vector(to_irq),
    .resume_after_sleep(to_resume), .goto_reset_vector(to_reset), .wake_source(src)
  );

  swc_far_model swc_far_model_i (.clk(clk), .arst_n(arst_n), .run({t2_run, t1_run}), .uf(tuf));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [1:0] lvl(input logic [2:0] b);
    return b == 3'h2 ? 2'h0 : b == 3'h7 ? 2'h1 : b == 3'h5 ? 2'h2 : 2'h3;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    check_count++;
    if (got !== want) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic cmp_wake(input swc_exp_t e);
    chk({2'h0, src, to_irq, to_resume, to_reset}, {2'h0, e}, "wake result");
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic sleep_at(input logic [15:0] c, input logic [15:0] g, input logic ie);
    logic idle;
    logic osc;
    logic mclk;
    logic [7:0] want;
    rnd = xs(rnd);
    idle = c[10];
    osc = c[9] | c[8];
    mclk = !idle & osc;
    @(posedge clk);
    csc <= {c[15:8], rnd[7:0]};
    igc <= g;
    gie <= ie;
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    want = {1'b1, 1'b0, mclk, mclk, osc, g[10] & (g[8] ? osc : mclk), g[11] & (g[9] ? osc : mclk), g[14]};
    chk({asleep, cpu_run, pll_run, mclk_run, ref_run, t1_run, t2_run, async_act}, want, "clocks");
    chk(mult, rnd[7:0], "multiplier");
    chk({6'h00, level}, {6'h00, lvl({idle, osc, g[14]})}, "level");
  endtask

  task automatic end_test(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, asleep}, 8'h00, "still asleep");
    chk({7'h00, cpu_run}, 8'h01, "cpu clock after wake");
    chk({7'h00, exp_q.size() == 0}, 8'h01, "wake missing");
    igc <= 16'h0000;
    pf <= 8'hFF;
    pd <= {8{~PORTD_RISE[0]}};
    rst_pin <= 1'b1;
    $display("test %s done", name);
  endtask

  task automatic settle(input int bitpos, input int want);
    int n;
    n = 0;
    @(posedge clk);
    csc <= 16'h0000;
    repeat (40) @(posedge clk);
    csc <= 16'h0001 << bitpos;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (full_speed === 1'b0) n++;
    end
    chk(n[7:0], want[7:0], "settle length");
  endtask

  always @(posedge clk) begin
    #1;
    if (wake_pulse === 1'b1) begin
      chk({7'h00, exp_q.size() != 0}, 8'h01, "unexpected wake");
      if (exp_q.size() != 0) cmp_wake(exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  initial begin
    rnd = 32'h0001_22E8;
    arst_n = 1'b0;
    sleep_instr = 1'b0;
    gie = 1'b0;
    csc = 16'h0100;
    igc = 16'h0000;
    conv_en = 1'b0;
    pdo = 1'b0;
    rst_pin = 1'b1;
    cuf = 1'b0;
    pf = 8'hFF;
    pd = {8{~PORTD_RISE[0]}};
    pdir = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    settle(9, XTAL);
    settle(8, TRIM);
    $display("test settle done");
    sleep_at(16'h0100, 16'h0402, 1'b1);
    exp_q.push_back({SRC_T1, 3'h4});
    end_test("light timer");
    sleep_at(16'h0500, 16'h4E06, 1'b0);
    exp_q.push_back({SRC_T2, 3'h2});
    end_test("mid timer");
    sleep_at(16'h0400, 16'h4F16, 1'b1);
    repeat (60) @(posedge clk);
    rnd = xs(rnd);
    exp_q.push_back({SRC_PORTF, 3'h4});
    pf[rnd[2:0]] <= 1'b0;
    end_test("deep port F");
    sleep_at(16'h0500, 16'h0F1F, 1'b1);
    repeat (60) @(posedge clk);
    pf <= 8'hFE;
    pd[2] <= ~pd[2];
    repeat (10) @(posedge clk);
    rst_pin <= 1'b0;
    @(posedge clk);
    exp_q.push_back({SRC_RESET, 3'h1});
    rst_pin <= 1'b1;
    end_test("reset only");
    conv_en <= 1'b1;
    sleep_at(16'h0100, 16'h0001, 1'b0);
    exp_q.push_back({SRC_CONV, 3'h2});
    cuf <= 1'b1;
    @(posedge clk);
    cuf <= 1'b0;
    conv_en <= 1'b0;
    end_test("light converter");
    sleep_at(16'h0100, 16'h0009, 1'b1);
    cuf <= 1'b1;
    pdir[3] <= 1'b1;
    pf <= 8'h00;
    @(posedge clk);
    cuf <= 1'b0;
    pd[3] <= ~pd[3];
    repeat (10) @(posedge clk);
    exp_q.push_back({SRC_PORTD, 3'h4});
    pd[2] <= ~pd[2];
    end_test("light port D");
    report_and_stop();
  end
endmodule

`default_nettype wire
